// [sts_pkg.sv]
// constants, command layout and types for the signaling test sequencer
`default_nettype none
package sts_pkg;
	// system clock rate used by the bit period generator
	localparam int CLK_HZ = 50_000_000;
	// command word layout
	localparam int CMD_W = 32;
	localparam int OP_LSB = 28;
	localparam int OP_W = 4;
	localparam int LBLV_BIT = 27;
	localparam int LBL_LSB = 19;
	localparam int LBL_W = 8;
	localparam int FRM_LSB = 12;
	localparam int FRM_W = 7;
	localparam int HSIG_BIT = 11;
	localparam int SEL_LSB = 8;
	localparam int SEL_W = 2;
	localparam int ARG_LSB = 0;
	localparam int SIG_W = 4;
	localparam int VAL_W = 8;
	localparam int WCNT_W = 12;
	// frame codes: bit 0 marks the special suffix, ignored by branch compares
	localparam logic [FRM_W-1:0] FRM_FIRST = 7'h02;
	localparam logic [FRM_W-1:0] FRM_LAST = 7'h7F;
	localparam logic [FRM_W-1:0] FRM_5A = 7'h40;
	localparam logic [FRM_W-1:0] FRM_13A = 7'h50;
	localparam logic [FRM_W-1:0] FRM_14A = 7'h52;
	localparam logic [FRM_W-1:0] FRM_14B = 7'h54;
	localparam logic [FRM_W-1:0] FRM_20 = 7'h60;
	localparam logic [FRM_W-1:0] FRM_25 = 7'h68;
	localparam logic [FRM_W-1:0] FRM_BASE_MASK = 7'h7E;
	// digit signal values: A..D are 10..13, then star and hash
	localparam logic [SIG_W-1:0] DIGIT_MAX = 4'hD;
	localparam logic [SIG_W-1:0] DIGIT_STAR = 4'hE;
	localparam logic [SIG_W-1:0] DIGIT_HASH = 4'hF;
	// counter indices
	localparam logic [SEL_W-1:0] SEL_CNT1 = 2'h1;
	localparam logic [SEL_W-1:0] SEL_CNT2 = 2'h2;
	// command opcodes
	typedef enum logic [OP_W-1:0] {
		OP_NOP, OP_SEND, OP_IF, OP_CLEAR, OP_SET, OP_REPEAT, OP_WAIT, OP_HALT
	} sts_op_t;
	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE, ST_EXEC, ST_SEND, ST_WAIT
	} sts_state_t;
endpackage
`default_nettype wire

// [sts_sequencer.sv]
// signaling test sequencer: stored command program driving frame encoder
//
// Behaviour
// - send command passes the chosen frame type, 1A to 30, to the encoder.
// - frame permission under the current standard is checked when the send executes.
// - frames 5a and 13a carry a line signal number 0 to 15.
// - frames 14a and 14b carry digits 0 to 13, star or hash.
// - frame 20 carries a channel activation order 0 to 15.
// - frame 25 carries channel status information 0 to 15.
// - conditional branch jumps to its label only when the received frame matches.
// - branch compare ignores the special suffix of the frame type.
// - labels are 0 to 255 and a jump target must exist.
// - clear command empties the received-frame register.
// - two counters, index 1 or 2, loaded with 0 to 255 by set.
// - repeat decrements the counter and branches while the new value exceeds zero.
// - wait idles, sending nothing, for 0 to 4095 bit periods.
// - bit period length follows the configured encoder bit rate.
// - any command may carry a label 0 to 255 used as a jump target.
`timescale 1ns/10ps
`default_nettype none
module sts_sequencer
	import sts_pkg::*;
#(
	parameter int AW = 8,
	parameter int RATE_W = 17
)
(
	// clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	// program load
	input wire logic prog_we_i,
	input wire logic [AW-1:0] prog_addr_i,
	input wire logic [sts_pkg::CMD_W-1:0] prog_data_i,
	// run control and configuration
	input wire logic run_i,
	input wire logic [(1<<sts_pkg::FRM_W)-1:0] std_allow_i,
	input wire logic [RATE_W-1:0] bit_rate_i,
	// frame encoder
	output logic frame_req_o,
	output logic [sts_pkg::FRM_W-1:0] frame_code_o,
	output logic frame_has_sig_o,
	output logic [sts_pkg::SIG_W-1:0] frame_sig_o,
	input wire logic frame_done_i,
	output logic idle_o,
	// frame decoder
	input wire logic rx_valid_i,
	input wire logic [sts_pkg::FRM_W-1:0] rx_code_i,
	// status
	output logic busy_o,
	output logic done_o,
	output logic err_o,
	output logic rx_full_o
);
	import sts_pkg::*;

	localparam int DEPTH = 1 << AW;
	localparam int ACC_W = $clog2(CLK_HZ) + 1;
	localparam logic [ACC_W-1:0] ACC_LIM = ACC_W'(CLK_HZ);
	localparam logic [AW-1:0] PC_LAST = {AW{1'b1}};

	// elaboration-time parameter checks
	if (AW < 1 || AW > 16)
		$error("sts_sequencer: AW out of range");
	if (RATE_W < 1 || RATE_W >= ACC_W)
		$error("sts_sequencer: RATE_W too wide");

	// strip the special suffix before comparing frames
	function automatic logic [FRM_W-1:0] frm_base(input logic [FRM_W-1:0] f);
		frm_base = f & FRM_BASE_MASK;
	endfunction

	// program store and label table
	logic [CMD_W-1:0] prog_mem [DEPTH];
	logic [AW-1:0] lbl_addr [256];
	logic [255:0] lbl_ok_reg;

	// state registers and next values
	sts_state_t st_reg, st_next;
	logic [AW-1:0] pc_reg, pc_next;
	logic [VAL_W-1:0] cnt1_reg, cnt1_next, cnt2_reg, cnt2_next;
	logic [WCNT_W-1:0] wcnt_reg, wcnt_next;
	logic [ACC_W-1:0] acc_reg, acc_next;
	logic rxf_reg, rxf_next;
	logic [FRM_W-1:0] rxc_reg, rxc_next;
	logic freq_reg, freq_next, fhs_reg, fhs_next, idle_reg, idle_next;
	logic [FRM_W-1:0] fcode_reg, fcode_next;
	logic [SIG_W-1:0] fsig_reg, fsig_next;
	logic busy_reg, busy_next, done_reg, done_next, err_reg, err_next;

	// fields of the current command
	logic [CMD_W-1:0] cmd;
	sts_op_t op;
	logic [FRM_W-1:0] frm;
	logic [SIG_W-1:0] sig;
	logic [LBL_W-1:0] tgt;
	logic [SEL_W-1:0] sel;
	logic [VAL_W-1:0] sel_cnt;
	logic [AW-1:0] tgt_addr;
	logic tgt_ok, if_match, is_sig_frm, sig_ok, send_ok;

	// command decode
	always_comb
	begin
		cmd = prog_mem[pc_reg];
		op = sts_op_t'(cmd[OP_LSB +: OP_W]);
		frm = cmd[FRM_LSB +: FRM_W];
		sig = cmd[ARG_LSB +: SIG_W];
		tgt = cmd[ARG_LSB +: LBL_W];
		sel = cmd[SEL_LSB +: SEL_W];
		sel_cnt = (sel == SEL_CNT2) ? cnt2_reg : cnt1_reg;
		tgt_addr = lbl_addr[tgt];
		tgt_ok = lbl_ok_reg[tgt];
		if_match = rxf_reg && (frm_base(rxc_reg) == frm_base(frm));
		is_sig_frm = (frm == FRM_5A) || (frm == FRM_13A) || (frm == FRM_14A) ||
			(frm == FRM_14B) || (frm == FRM_20) || (frm == FRM_25);
		// digit frames take 0..13 plus star and hash; others take any nibble
		if ((frm == FRM_14A) || (frm == FRM_14B))
			sig_ok = (sig <= DIGIT_MAX) || (sig == DIGIT_STAR) || (sig == DIGIT_HASH);
		else
			sig_ok = 1'b1;
		send_ok = (frm >= FRM_FIRST) && (frm <= FRM_LAST) && std_allow_i[frm] &&
			(cmd[HSIG_BIT] == is_sig_frm) && sig_ok;
	end

	// program and label table load, ignored while a test runs
	always_ff @(posedge ref_clk_i)
	begin
		if (ce_i && prog_we_i && !busy_reg)
		begin
			prog_mem[prog_addr_i] <= prog_data_i;
			if (prog_data_i[LBLV_BIT])
				lbl_addr[prog_data_i[LBL_LSB +: LBL_W]] <= prog_addr_i;
		end
	end

	// label presence flags
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
			lbl_ok_reg <= '0;
		else if (ce_i && prog_we_i && !busy_reg && prog_data_i[LBLV_BIT])
			lbl_ok_reg[prog_data_i[LBL_LSB +: LBL_W]] <= 1'b1;
	end

	// sequencer next state
	always_comb
	begin
		logic adv, jmp, fail, clr;
		logic [VAL_W-1:0] dec;
		logic [ACC_W-1:0] acc_sum;
		adv = 1'b0;
		jmp = 1'b0;
		fail = 1'b0;
		clr = 1'b0;
		dec = (sel_cnt == '0) ? '0 : sel_cnt - 1'b1;
		acc_sum = acc_reg + ACC_W'(bit_rate_i);
		st_next = st_reg;
		pc_next = pc_reg;
		cnt1_next = cnt1_reg;
		cnt2_next = cnt2_reg;
		wcnt_next = wcnt_reg;
		acc_next = acc_reg;
		freq_next = freq_reg;
		fcode_next = fcode_reg;
		fhs_next = fhs_reg;
		fsig_next = fsig_reg;
		idle_next = idle_reg;
		busy_next = busy_reg;
		done_next = done_reg;
		err_next = err_reg;
		case (st_reg)
			ST_IDLE:
			begin
				if (run_i)
				begin
					pc_next = '0;
					busy_next = 1'b1;
					done_next = 1'b0;
					err_next = 1'b0;
					st_next = ST_EXEC;
				end
			end
			ST_EXEC:
			begin
				case (op)
					OP_NOP: adv = 1'b1;
					OP_SEND:
					begin
						if (send_ok)
						begin
							freq_next = 1'b1;
							fcode_next = frm;
							fhs_next = cmd[HSIG_BIT];
							fsig_next = sig;
							st_next = ST_SEND;
						end
						else
							fail = 1'b1;
					end
					OP_IF:
					begin
						if (if_match)
							jmp = 1'b1;
						else
							adv = 1'b1;
					end
					OP_CLEAR:
					begin
						clr = 1'b1;
						adv = 1'b1;
					end
					OP_SET:
					begin
						adv = 1'b1;
						if (sel == SEL_CNT1)
							cnt1_next = cmd[ARG_LSB +: VAL_W];
						else if (sel == SEL_CNT2)
							cnt2_next = cmd[ARG_LSB +: VAL_W];
						else
							fail = 1'b1;
					end
					OP_REPEAT:
					begin
						if (sel == SEL_CNT1)
							cnt1_next = dec;
						else if (sel == SEL_CNT2)
							cnt2_next = dec;
						else
							fail = 1'b1;
						if (dec != '0)
							jmp = 1'b1;
						else
							adv = 1'b1;
					end
					OP_WAIT:
					begin
						if (cmd[ARG_LSB +: WCNT_W] == '0)
							adv = 1'b1;
						else
						begin
							wcnt_next = cmd[ARG_LSB +: WCNT_W];
							acc_next = '0;
							idle_next = 1'b1;
							st_next = ST_WAIT;
						end
					end
					OP_HALT:
					begin
						busy_next = 1'b0;
						done_next = 1'b1;
						st_next = ST_IDLE;
					end
					default: fail = 1'b1;
				endcase
			end
			ST_SEND:
			begin
				if (frame_done_i)
				begin
					freq_next = 1'b0;
					adv = 1'b1;
				end
			end
			ST_WAIT:
			begin
				// phase accumulator: one bit period per CLK_HZ/rate cycles
				if (acc_sum >= ACC_LIM)
				begin
					acc_next = acc_sum - ACC_LIM;
					wcnt_next = wcnt_reg - 1'b1;
					if (wcnt_reg == 12'h001)
					begin
						idle_next = 1'b0;
						adv = 1'b1;
					end
				end
				else
					acc_next = acc_sum;
			end
			default: fail = 1'b1;
		endcase
		// advance, jump or stop on a fault
		if (jmp && !tgt_ok)
			fail = 1'b1;
		if (adv && pc_reg == PC_LAST)
			fail = 1'b1;
		if (fail)
		begin
			err_next = 1'b1;
			busy_next = 1'b0;
			freq_next = 1'b0;
			idle_next = 1'b0;
			st_next = ST_IDLE;
		end
		else if (jmp)
		begin
			pc_next = tgt_addr;
			st_next = ST_EXEC;
		end
		else if (adv)
		begin
			pc_next = pc_reg + 1'b1;
			st_next = ST_EXEC;
		end
		// received register: a frame arriving with a clear wins
		rxf_next = rxf_reg;
		rxc_next = rxc_reg;
		if (clr)
			rxf_next = 1'b0;
		if (rx_valid_i)
		begin
			rxf_next = 1'b1;
			rxc_next = rx_code_i;
		end
	end

	// state registers
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
		begin
			st_reg <= ST_IDLE;
			pc_reg <= '0;
			cnt1_reg <= '0;
			cnt2_reg <= '0;
			wcnt_reg <= '0;
			acc_reg <= '0;
			rxf_reg <= 1'b0;
			rxc_reg <= '0;
			freq_reg <= 1'b0;
			fcode_reg <= '0;
			fhs_reg <= 1'b0;
			fsig_reg <= '0;
			idle_reg <= 1'b0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			err_reg <= 1'b0;
		end
		else if (ce_i)
		begin
			st_reg <= st_next;
			pc_reg <= pc_next;
			cnt1_reg <= cnt1_next;
			cnt2_reg <= cnt2_next;
			wcnt_reg <= wcnt_next;
			acc_reg <= acc_next;
			rxf_reg <= rxf_next;
			rxc_reg <= rxc_next;
			freq_reg <= freq_next;
			fcode_reg <= fcode_next;
			fhs_reg <= fhs_next;
			fsig_reg <= fsig_next;
			idle_reg <= idle_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
			err_reg <= err_next;
		end
	end

	// outputs straight from registers
	assign frame_req_o = freq_reg;
	assign frame_code_o = fcode_reg;
	assign frame_has_sig_o = fhs_reg;
	assign frame_sig_o = fsig_reg;
	assign idle_o = idle_reg;
	assign busy_o = busy_reg;
	assign done_o = done_reg;
	assign err_o = err_reg;
	assign rx_full_o = rxf_reg;

	// checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);

	a_req_held: assert property (freq_reg && !(ce_i && frame_done_i) |=> freq_reg)
		else $error("frame request dropped before done");
	a_req_release: assert property (freq_reg && ce_i && frame_done_i |=> !freq_reg)
		else $error("frame request held after done");
	a_clear_empties: assert property (ce_i && st_reg == ST_EXEC && op == OP_CLEAR &&
		!rx_valid_i |=> !rxf_reg)
		else $error("clear left received register full");
	a_rx_set_wins: assert property (ce_i && rx_valid_i |=> rxf_reg &&
		rxc_reg == $past(rx_code_i))
		else $error("received frame lost");
	a_wait_silent: assert property (idle_reg |-> !freq_reg)
		else $error("frame sent during wait");
	a_set_loads: assert property (ce_i && st_reg == ST_EXEC && op == OP_SET &&
		sel == SEL_CNT1 |=> cnt1_reg == $past(cmd[ARG_LSB +: VAL_W]))
		else $error("set did not load counter 1");
	a_if_jumps: assert property (ce_i && st_reg == ST_EXEC && op == OP_IF && if_match &&
		tgt_ok |=> pc_reg == $past(tgt_addr) && st_reg == ST_EXEC)
		else $error("matching branch not taken");
	a_repeat_falls: assert property (ce_i && st_reg == ST_EXEC && op == OP_REPEAT &&
		sel == SEL_CNT1 && cnt1_reg <= 8'h01 && pc_reg != PC_LAST |=> pc_reg == $past(pc_reg) + 1'b1)
		else $error("repeat branched at zero");
	a_send_denied: assert property (ce_i && st_reg == ST_EXEC && op == OP_SEND &&
		!std_allow_i[frm] |=> err_reg && !freq_reg)
		else $error("frame not permitted was sent");
endmodule
`default_nettype wire

// [sts_far_end.sv]
// far-end model: frame encoder completion and echoing frame decoder
`timescale 1ns/10ps
`default_nettype none
module sts_far_end (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	// encoder side
	input wire logic frame_req_i,
	input wire logic [6:0] frame_code_i,
	input wire logic slow_i,
	output logic frame_done_o = 1'b0,
	// decoder side
	output logic rx_valid_o = 1'b0,
	output logic [6:0] rx_code_o = 7'h55
);
	int cnt = 0;
	// finish a frame after 1 or 7 cycles and echo its code back as received
	always @(posedge ref_clk_i)
	begin
		rx_valid_o <= 1'b0;
		rx_code_o <= ~rx_code_o; // code bus is meaningless outside a valid pulse
		frame_done_o <= 1'b0;
		if (!reset_n_i || !frame_req_i || frame_done_o)
			cnt <= 0;
		else if (cnt == (slow_i ? 6 : 0))
		begin
			frame_done_o <= 1'b1;
			rx_valid_o <= 1'b1;
			rx_code_o <= frame_code_i;
		end
		else
			cnt <= cnt + 1;
	end
endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the signaling test sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
	import sts_pkg::*;
	logic ref_clk_i = 0, reset_n_i = 0, prog_we_i = 0, run_i = 0, slow = 0;
	logic [7:0] prog_addr_i = 8'h00;
	logic [31:0] prog_data_i = 32'h0;
	logic [127:0] std_allow_i = '1;
	logic frame_req_o, frame_has_sig_o, frame_done_i, idle_o, rx_valid_i;
	logic busy_o, done_o, err_o, rx_full_o;
	logic [6:0] frame_code_o, rx_code_i;
	logic [3:0] frame_sig_o, s0, s1, s2, s3;
	logic [31:0] prog [16];
	int n_fail = 0, checks_done = 0, seed = 8120, idle_n = 0, r;
	int exp_q[$];

	sts_sequencer #(.AW(8), .RATE_W(23)) u_sts_sequencer (.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i), .ce_i(1'b1), .prog_we_i(prog_we_i), .prog_addr_i(prog_addr_i),
		.prog_data_i(prog_data_i), .run_i(run_i), .std_allow_i(std_allow_i),
		.bit_rate_i(23'h4C4B40), .frame_req_o(frame_req_o), .frame_code_o(frame_code_o),
		.frame_has_sig_o(frame_has_sig_o), .frame_sig_o(frame_sig_o),
		.frame_done_i(frame_done_i), .idle_o(idle_o), .rx_valid_i(rx_valid_i),
		.rx_code_i(rx_code_i), .busy_o(busy_o), .done_o(done_o), .err_o(err_o),
		.rx_full_o(rx_full_o));
	sts_far_end u_sts_far_end (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
		.frame_req_i(frame_req_o), .frame_code_i(frame_code_o), .slow_i(slow),
		.frame_done_o(frame_done_i), .rx_valid_o(rx_valid_i), .rx_code_o(rx_code_i));

	// verdict and end of run
	task automatic test_done();
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// one comparison
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected %s: expected %0h, seen %0h", what, exp, got);
		end
	endtask
	// build a command word
	function automatic logic [31:0] cw(int op, int lb, int frm, int hs, int sel, int arg);
		cw = (op << OP_LSB) | (frm << FRM_LSB) | (hs << HSIG_BIT) | (sel << SEL_LSB) | arg;
		if (lb >= 0)
			cw = cw | (1 << LBLV_BIT) | (lb << LBL_LSB);
	endfunction
	// start a run and wait for it to halt or fault
	task automatic go(logic sl);
		int i;
		slow <= sl;
		@(posedge ref_clk_i);
		run_i <= 1'b1;
		@(posedge ref_clk_i);
		run_i <= 1'b0;
		@(posedge ref_clk_i);
		for (i = 0; i < 5000 && done_o !== 1'b1 && err_o !== 1'b1; i++)
			@(posedge ref_clk_i);
		if (i == 5000)
		begin
			n_fail++;
			test_done();
		end
	endtask

	// clock
	initial
	begin
		forever #10 ref_clk_i = ~ref_clk_i;
	end
	// frame monitor and wait watcher
	always @(posedge ref_clk_i)
	begin
		if (frame_req_o === 1'b1 && frame_done_i === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk("extra frame", 0, 1);
			else
				chk("frame", exp_q.pop_front(), {frame_code_o, frame_has_sig_o, frame_sig_o});
		end
		if (idle_o === 1'b1)
			idle_n++;
		if (idle_o === 1'b1 && frame_req_o !== 1'b0)
			chk("send during wait", 0, 1);
	end
	// main sequence
	initial
	begin
		s0 = 4'($random(seed));
		s1 = 4'($random(seed));
		s2 = 4'($random(seed));
		s3 = 4'($random(seed));
		// program: counted loop, signal frames, wait, clear and branches
		prog = '{cw(OP_SET, -1, 0, 0, 1, 3), cw(OP_SEND, 5, 'h40, 1, 0, s0),
			cw(OP_REPEAT, -1, 0, 0, 1, 5), cw(OP_SEND, -1, 'h52, 1, 0, s1),
			cw(OP_SEND, -1, 'h60, 1, 0, s2), cw(OP_SEND, -1, 'h68, 1, 0, s3),
			cw(OP_WAIT, -1, 0, 0, 0, 2), cw(OP_CLEAR, -1, 0, 0, 0, 0),
			cw(OP_IF, -1, 'h68, 0, 0, 9), cw(OP_SEND, -1, 'h03, 0, 0, 0),
			cw(OP_IF, 9, 'h02, 0, 0, 12), cw(OP_SEND, -1, 'h04, 0, 0, 0),
			cw(OP_SEND, 12, 'h06, 0, 0, 0), cw(OP_SET, -1, 0, 0, 2, 1),
			cw(OP_REPEAT, -1, 0, 0, 2, 5), cw(OP_HALT, -1, 0, 0, 0, 0)};
		repeat (4) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		for (r = 0; r < 16; r++)
		begin
			@(posedge ref_clk_i);
			prog_we_i <= 1'b1;
			prog_addr_i <= r[7:0];
			prog_data_i <= prog[r];
		end
		@(posedge ref_clk_i);
		prog_we_i <= 1'b0;
		// same program with a prompt and then a slow encoder
		for (r = 0; r < 2; r++)
		begin
			repeat (3) exp_q.push_back({7'h40, 1'b1, s0});
			exp_q.push_back({7'h52, 1'b1, s1});
			exp_q.push_back({7'h60, 1'b1, s2});
			exp_q.push_back({7'h68, 1'b1, s3});
			exp_q.push_back({7'h03, 5'h00});
			exp_q.push_back({7'h06, 5'h00});
			idle_n = 0;
			go(r[0]);
			chk("done", 1, done_o);
			chk("err", 0, err_o);
			chk("frames left", 0, exp_q.size());
			chk("wait length", 1, idle_n >= 19 && idle_n <= 21);
			chk("rx full", 1, rx_full_o);
		end
		// frame forbidden under the standard chosen after loading
		@(posedge ref_clk_i);
		prog_we_i <= 1'b1;
		prog_addr_i <= 8'h00;
		prog_data_i <= cw(OP_SEND, -1, 'h02, 0, 0, 0);
		std_allow_i <= ~(128'h1 << 2);
		@(posedge ref_clk_i);
		prog_we_i <= 1'b0;
		go(1'b0);
		chk("err on forbidden frame", 1, err_o);
		chk("busy after fault", 0, busy_o);
		// counter loaded, then a loop back to a label that was never loaded
		std_allow_i <= '1;
		@(posedge ref_clk_i);
		prog_we_i <= 1'b1;
		prog_addr_i <= 8'h00;
		prog_data_i <= cw(OP_SET, -1, 0, 0, 1, 2);
		@(posedge ref_clk_i);
		prog_addr_i <= 8'h01;
		prog_data_i <= cw(OP_REPEAT, -1, 0, 0, 1, 200);
		@(posedge ref_clk_i);
		prog_we_i <= 1'b0;
		go(1'b0);
		chk("err on missing label", 1, err_o);
		chk("busy after missing label", 0, busy_o);
		test_done();
	end
endmodule
`default_nettype wire
